// ### bench/pcsr_host.sv
// Host model: register port master with write and read tasks.
// Assumes rdata answers one cycle after the address.
`default_nettype none
module pcsr_host
   import pcsr_pkg::*;
(
   // Clock
   input wire logic mclk,
   // Register port
   output pcsr_req_t req,
   output logic reqValid,
   input wire logic [7:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle port
   initial begin
      req = '{wr: 1'b0, addr: 8'h13, wdata: 8'h00};
      reqValid = 1'b0;
   end
   // One-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      d[1:0] = (a == ADDR_RESET && d[1:0] == 2'h3) ? 2'h2 : d[1:0];
      @(posedge mclk);
      req <= '{wr: 1'b1, addr: a, wdata: d};
      reqValid <= 1'b1;
      @(posedge mclk);
      req.wr <= 1'b0;
      reqValid <= 1'b0;
   endtask
   // Address, then data one edge later
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      req.addr <= a;
      @(posedge mclk);
      #1 d = rdata;
   endtask
endmodule // pcsr_host
`default_nettype wire

// ### bench/pcsr_regs_checker.sv
// Port assertions for the register bank.
// Assumes it is bound onto pcsr_regs and sees only its ports.
`default_nettype none
module pcsr_regs_checker
   import pcsr_pkg::*;
#(parameter logic [7:0] ENABLE_DEFAULT = 8'h05, PRODUCT_CODE = 8'h5A,
   parameter logic [3:0] REVISION_CODE = 4'h7, VARIANT_CODE = 4'h4) (
   // Watched ports
   input wire logic mclk, resetn, reqValid, internalResetDone, thermalCleared,
   input wire pcsr_req_t req,
   input wire logic [7:0] rdata,
   input wire pcsr_sense_t sense,
   input wire logic [3:0] outputGood,
   input wire logic [1:0] scalingDone,
   input wire pcsr_ctrl_t ctrl,
   input wire logic powerUpStart, latchedOff, powerGood);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Helpers
   wire logic wrEn = reqValid && req.wr;
   wire logic allGood = &outputGood && &scalingDone && internalResetDone;
   wire logic [7:0] senseLive = sense & 8'hF7;
   wire logic [3:0] dischBits = {req.wdata[5:4], req.wdata[1:0]};
   wire logic [1:0] modeBits = {req.wdata[2], req.wdata[0]};
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   // Properties
   property p_sense; req.addr == ADDR_SENSE |=> rdata == $past(senseLive); endproperty
   a_sense: assert property (p_sense) else $error("sense read");
   property p_pid; req.addr == ADDR_PRODUCT |=> rdata == PRODUCT_CODE; endproperty
   a_pid: assert property (p_pid) else $error("product code");
   property p_rfid; req.addr == ADDR_RFID |=> rdata == {REVISION_CODE, VARIANT_CODE}; endproperty
   a_rfid: assert property (p_rfid) else $error("revision code");
   property p_hole; req.addr == 8'h13 |=> rdata == 8'h00; endproperty
   a_hole: assert property (p_hole) else $error("hole read");
   property p_force; wrEn && req.addr == ADDR_RESET && req.wdata[FORCE_BIT] |=>
      ctrl.discharge == 4'hF && ctrl.forcedPwm == {ENABLE_DEFAULT[2], ENABLE_DEFAULT[0]};
   endproperty
   a_force: assert property (p_force) else $error("force");
   property p_disch; wrEn && req.addr == ADDR_DISCH |=> ctrl.discharge == $past(dischBits);
   endproperty
   a_disch: assert property (p_disch) else $error("discharge");
   property p_mode; wrEn && req.addr == ADDR_ENABLE |=> ctrl.forcedPwm == $past(modeBits);
   endproperty
   a_mode: assert property (p_mode) else $error("mode");
   property p_trip; $rose(sense.thermal_shutdown_live) |=> latchedOff; endproperty
   a_trip: assert property (p_trip) else $error("trip");
   property p_gate; latchedOff |-> ctrl.outOn == 4'h0; endproperty
   a_gate: assert property (p_gate) else $error("gate");
   property p_pg; allGood [*2] |-> powerGood; endproperty
   a_pg: assert property (p_pg) else $error("power good");
   cover property (powerUpStart);
   cover property (latchedOff && thermalCleared);
   cover property (wrEn && req.wdata[FORCE_BIT] && req.addr == ADDR_RESET);
endmodule // pcsr_regs_checker
bind pcsr_regs pcsr_regs_checker #(.ENABLE_DEFAULT(ENABLE_DEFAULT), .PRODUCT_CODE(PRODUCT_CODE),
   .REVISION_CODE(REVISION_CODE), .VARIANT_CODE(VARIANT_CODE)) pcsr_regs_checker_inst (.mclk,
   .resetn, .reqValid, .internalResetDone, .thermalCleared, .req, .rdata, .sense, .outputGood,
   .scalingDone, .ctrl, .powerUpStart, .latchedOff, .powerGood);
`default_nettype wire

// ### bench/pcsr_regs_tb.sv
// Self-checking bench of the register bank.
// Assumes the host model and the bound checker.
`default_nettype none
module pcsr_regs_tb
   import pcsr_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0, resetn = 1'b0, internalResetDone = 1'b0, thermalCleared = 1'b0;
   logic reqValid, powerUpStart, latchedOff, powerGood;
   logic [7:0] rdata, d;
   logic [3:0] outputGood = 4'h0;
   logic [1:0] scalingDone = 2'h0;
   pcsr_req_t req;
   pcsr_sense_t sense = '0;
   pcsr_ctrl_t ctrl;
   int mismatches = 0, num_checks = 0, starts = 0;
   logic [7:0] ra [8] = '{ADDR_SENSE, ADDR_RESET, ADDR_DISCH, ADDR_PGASSIGN, ADDR_ENABLE,
      ADDR_PRODUCT, ADDR_RFID, 8'h13};
   logic [7:0] rv0 [8] = '{8'h00, 8'h10, 8'h33, 8'h42, 8'hCF, 8'h5A, 8'h74, 8'h00};
   logic [7:0] rv1 [8] = '{8'h00, 8'h12, 8'h32, 8'h7E, 8'h4E, 8'h5A, 8'h74, 8'h00};
   // ==========================================================
   // Design and host
   pcsr_regs #(.ENABLE_DEFAULT(8'hFF)) pcsr_regs_inst (.mclk, .resetn, .req, .reqValid, .rdata,
      .sense, .outputGood, .scalingDone, .internalResetDone, .thermalCleared, .ctrl,
      .powerUpStart, .latchedOff, .powerGood);
   pcsr_host pcsr_host_inst (.mclk, .req, .reqValid, .rdata);
   // Clock and power-up pulse count
   always #5 mclk = ~mclk;
   always @(posedge mclk) if (powerUpStart === 1'b1) starts <= starts + 1;
   // Compare and count
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] exp);
      pcsr_host_inst.rd(a, d);
      chk(d, exp);
   endtask
   // Thermal trip and exit under a recovery code
   task automatic trip(input logic [1:0] code);
      pcsr_host_inst.wr(ADDR_RESET, {6'h0, code});
      @(posedge mclk) sense.thermal_shutdown_live <= 1'b1;
      thermalCleared <= 1'b1;
      @(posedge mclk) sense.thermal_shutdown_live <= 1'b0;
      repeat (3) @(posedge mclk);
      thermalCleared <= 1'b0;
   endtask
   task automatic pg(input logic [3:0] g, input logic [7:0] exp);
      @(posedge mclk) outputGood <= g;
      repeat (3) @(posedge mclk);
      #1 chk({7'h0, powerGood}, exp);
   endtask
   task automatic results();
      $display("checks=%0d mismatches=%0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Watchdog
   initial begin
      #50us;
      mismatches++;
      results();
   end
   // Test sequence
   initial begin
      repeat (3) @(posedge mclk);
      resetn <= 1'b1;
      foreach (ra[i]) rc(ra[i], rv0[i]);
      $display("reset values done");
      foreach (ra[i]) pcsr_host_inst.wr(ra[i], 8'h7E);
      foreach (ra[i]) rc(ra[i], rv1[i]);
      chk({4'h0, ctrl.outOn}, 8'h07);
      $display("write masks done");
      // Last bit trips shutdown; it stays latched until the recovery tests
      for (int i = 0; i < 8; i++) begin
         @(posedge mclk) sense <= pcsr_sense_t'(8'h01 << i);
         rc(ADDR_SENSE, (8'h01 << i) & 8'hF7);
      end
      @(posedge mclk) sense <= '0;
      rc(ADDR_SENSE, 8'h00);
      $display("sense done");
      pcsr_host_inst.wr(ADDR_RESET, 8'h80);
      foreach (ra[i]) rc(ra[i], rv0[i]);
      $display("force done");
      @(posedge mclk) scalingDone <= 2'h3;
      internalResetDone <= 1'b1;
      pg(4'hF, 8'h01);
      pcsr_host_inst.wr(ADDR_PGASSIGN, 8'h01);
      pg(4'hD, 8'h01);
      pg(4'hC, 8'h00);
      $display("power good done");
      pcsr_host_inst.wr(ADDR_DISCH, 8'h00);
      trip(2'h0);
      chk(8'(starts), 8'h01);
      rc(ADDR_DISCH, 8'h33);
      rc(ADDR_RESET, 8'h10);
      pcsr_host_inst.wr(ADDR_DISCH, 8'h01);
      trip(2'h1);
      chk(8'(starts), 8'h02);
      rc(ADDR_DISCH, 8'h01);
      trip(2'h2);
      chk({latchedOff, 3'h0, ctrl.outOn}, 8'h80);
      chk(8'(starts), 8'h02);
      $display("recovery done");
      results();
   end
endmodule // pcsr_regs_tb
`default_nettype wire

// ### design/pcsr_pg_merge.sv
// Power-good pin composer: ANDs every assigned source.
// Assumes sources are live levels synchronous to mclk.
`default_nettype none

module pcsr_pg_merge
   import pcsr_pkg::*;
#(
   parameter int N = PG_SOURCES
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Sources and assignment
   input wire logic [N-1:0] sources,
   input wire logic [N-1:0] assign_,
   // Pin level
   output logic powerGood
);
   // ==========================================================
   // Unassigned sources count as good
   logic [N-1:0] passMask;
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_src
         assign passMask[i] = sources[i] | ~assign_[i];
      end
   endgenerate

   // Registered pin level
   always_ff @(posedge mclk) begin
      if (!resetn) powerGood <= 1'b0;
      else powerGood <= &passMask;
   end
endmodule // pcsr_pg_merge

`default_nettype wire

// ### design/pcsr_regs.sv
// Control/status register bank of a four-output PMIC, behind the byte register port.
// Assumes the serial front end delivers single-cycle read/write strobes on mclk.
`default_nettype none

module pcsr_regs
   import pcsr_pkg::*;
#(
   parameter logic [7:0] ENABLE_DEFAULT = 8'h05, // Factory fuse value, arbitrary
   parameter logic [7:0] PRODUCT_CODE = 8'h5A, // Arbitrary value
   parameter logic [3:0] REVISION_CODE = 4'h7, // Arbitrary value
   parameter logic [3:0] VARIANT_CODE = 4'h4 // Arbitrary value
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Register port
   input wire pcsr_req_t req,
   input wire logic reqValid,
   output logic [7:0] rdata,
   // Live analog conditions
   input wire pcsr_sense_t sense,
   input wire logic [3:0] outputGood,
   input wire logic [1:0] scalingDone,
   input wire logic internalResetDone,
   // Shutdown recovery from the analog side
   input wire logic thermalCleared,
   // Controls
   output pcsr_ctrl_t ctrl,
   output logic powerUpStart,
   output logic latchedOff,
   output logic powerGood
);
   // ==========================================================
   // Registers
   logic [7:0] resetCtrl_q, resetCtrl_d;
   logic [7:0] enable_q, enable_d;
   logic [7:0] disch_q, disch_d;
   logic [7:0] pgAssign_q, pgAssign_d;
   logic [7:0] rdata_d;
   logic off_q, off_d;
   logic start_q, start_d;
   logic tripSeen_q;

   // ==========================================================
   // Address decode
   logic wrStrobe;
   logic wrReset, wrEnable, wrDisch, wrPg;
   logic forceDefaults;
   logic tripRise, tripFall;
   logic [1:0] recovery;
   logic restoreDefaults;
   assign wrStrobe = reqValid & req.wr;
   assign wrReset = wrStrobe & (req.addr == ADDR_RESET);
   assign wrEnable = wrStrobe & (req.addr == ADDR_ENABLE);
   assign wrDisch = wrStrobe & (req.addr == ADDR_DISCH);
   assign wrPg = wrStrobe & (req.addr == ADDR_PGASSIGN);

   // Shutdown edges and recovery choice
   assign recovery = resetCtrl_q[1:0];
   assign tripRise = sense.thermal_shutdown_live & ~tripSeen_q;
   assign tripFall = tripSeen_q & thermalCleared & ~sense.thermal_shutdown_live;
   assign forceDefaults = wrReset & req.wdata[FORCE_BIT];
   assign restoreDefaults = forceDefaults | (tripFall & (recovery == RECOVER_DEFAULTS));

   // Next value of reset control; the force bit self-clears
   always_comb begin
      resetCtrl_d = resetCtrl_q;
      if (restoreDefaults) resetCtrl_d = RESET_CTRL_DEFAULT;
      else if (wrReset) resetCtrl_d = req.wdata & RESET_CTRL_MASK;
   end

   // Next values of output controls
   always_comb begin
      enable_d = enable_q;
      disch_d = disch_q;
      pgAssign_d = pgAssign_q;
      if (restoreDefaults) begin
         enable_d = ENABLE_DEFAULT & ENABLE_MASK;
         disch_d = DISCH_DEFAULT;
         pgAssign_d = PGASSIGN_DEFAULT;
      end else begin
         if (wrEnable) enable_d = req.wdata & ENABLE_MASK;
         if (wrDisch) disch_d = req.wdata & DISCH_MASK;
         if (wrPg) pgAssign_d = req.wdata & PGASSIGN_MASK;
      end
   end

   // Shutdown state: off from detection; re-arm unless code says stay off
   always_comb begin
      off_d = off_q;
      start_d = 1'b0;
      if (tripRise) off_d = 1'b1;
      else if (tripFall && recovery != RECOVER_NONE) begin
         off_d = 1'b0;
         start_d = 1'b1;
      end else if (tripFall) off_d = 1'b1;
   end

   // Read mux; live sense, spare bit forced low
   always_comb begin
      case (req.addr)
         ADDR_SENSE: rdata_d = {sense[7:4], 1'b0, sense[2:0]};
         ADDR_RESET: rdata_d = resetCtrl_q;
         ADDR_PRODUCT: rdata_d = PRODUCT_CODE;
         ADDR_RFID: rdata_d = {REVISION_CODE, VARIANT_CODE};
         ADDR_ENABLE: rdata_d = enable_q;
         ADDR_DISCH: rdata_d = disch_q;
         ADDR_PGASSIGN: rdata_d = pgAssign_q;
         default: rdata_d = 8'h00;
      endcase
   end

   // Register update
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         resetCtrl_q <= RESET_CTRL_DEFAULT;
         enable_q <= ENABLE_DEFAULT & ENABLE_MASK;
         disch_q <= DISCH_DEFAULT;
         pgAssign_q <= PGASSIGN_DEFAULT;
         off_q <= 1'b0;
         start_q <= 1'b0;
         tripSeen_q <= 1'b0;
         rdata <= 8'h00;
      end else begin
         resetCtrl_q <= resetCtrl_d;
         enable_q <= enable_d;
         disch_q <= disch_d;
         pgAssign_q <= pgAssign_d;
         off_q <= off_d;
         start_q <= start_d;
         tripSeen_q <= sense.thermal_shutdown_live;
         rdata <= rdata_d;
      end
   end

   // ==========================================================
   // Controls to the power stages; outputs forced off while shut down
   assign ctrl = '{
      outOn: off_q ? 4'h0 : {enable_q[7], enable_q[6], enable_q[3], enable_q[1]},
      forcedPwm: {enable_q[2], enable_q[0]},
      discharge: {disch_q[5], disch_q[4], disch_q[1], disch_q[0]}
   };
   assign powerUpStart = start_q;
   assign latchedOff = off_q;

   // Power-good pin: rst, reg4, reg3, scaling2, scaling1, buck2, buck1
   pcsr_pg_merge #(.N(PG_SOURCES)) u_pg (
      .mclk(mclk),
      .resetn(resetn),
      .sources({internalResetDone, outputGood[3], outputGood[2], scalingDone[1],
                scalingDone[0], outputGood[1], outputGood[0]}),
      .assign_(pgAssign_q[6:0]),
      .powerGood(powerGood)
   );
endmodule // pcsr_regs

`default_nettype wire

// ### shared/pcsr_pkg.sv
// Constants, field layouts and carrier types of the PMIC control/status register bank.
// Assumes a byte-wide register port, one register per address.
`default_nettype none

package pcsr_pkg;
   // ==========================================================
   // Register addresses
   localparam logic [7:0] ADDR_SENSE = 8'h03;
   localparam logic [7:0] ADDR_RESET = 8'h10;
   localparam logic [7:0] ADDR_PRODUCT = 8'h11;
   localparam logic [7:0] ADDR_RFID = 8'h12;
   localparam logic [7:0] ADDR_ENABLE = 8'h14;
   localparam logic [7:0] ADDR_DISCH = 8'h15;
   localparam logic [7:0] ADDR_PGASSIGN = 8'h16;

   // ==========================================================
   // Reset values and writable masks
   localparam logic [7:0] RESET_CTRL_DEFAULT = 8'h10;
   localparam logic [7:0] DISCH_DEFAULT = 8'h33;
   localparam logic [7:0] PGASSIGN_DEFAULT = 8'h42;
   localparam logic [7:0] RESET_CTRL_MASK = 8'h13;
   localparam logic [7:0] ENABLE_MASK = 8'hCF;
   localparam logic [7:0] DISCH_MASK = 8'h33;
   localparam logic [7:0] PGASSIGN_MASK = 8'h7F;

   // ==========================================================
   // Field positions and power-good source count
   localparam int FORCE_BIT = 7;
   localparam int FLAG_BIT = 4;
   localparam int PG_SOURCES = 7;

   // ==========================================================
   // Recovery codes after thermal shutdown
   localparam logic [1:0] RECOVER_DEFAULTS = 2'h0;
   localparam logic [1:0] RECOVER_KEEP = 2'h1;
   localparam logic [1:0] RECOVER_NONE = 2'h2;

   // Live fault conditions, bit order as the sense register
   typedef struct packed {
      logic thermal_shutdown_live;
      logic thermal_warning_live;
      logic reg4_overcurrent_live;
      logic reg3_overcurrent_live;
      logic spare;
      logic input_undervoltage_live;
      logic buck2_overcurrent_live;
      logic buck1_overcurrent_live;
   } pcsr_sense_t;

   // Register-port request
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pcsr_req_t;

   // Controls to the power stages
   typedef struct packed {
      logic [3:0] outOn;
      logic [1:0] forcedPwm;
      logic [3:0] discharge;
   } pcsr_ctrl_t;
endpackage

`default_nettype wire
